/* epa_consts.svh */
// Offsets, reset values and field positions of the eight-bit port
`ifndef EPA_CONSTS_SVH
`define EPA_CONSTS_SVH
`define EPA_ADDR_W        16
`define EPA_DIR_OFFSET    16'hffd1
`define EPA_DATA_OFFSET   16'hffd3
`define EPA_DIR_RESET     8'h00
`define EPA_DATA_RESET    8'h00
`define EPA_DIR_READBACK  8'hff
`define EPA_UNMAPPED_READ 8'h00
`define EPA_ADDR_PIN      7
`define EPA_MODE_ADDR_A   3'h3
`define EPA_MODE_ADDR_B   3'h4
`endif

/* epa_pkg.sv */
// Types shared by the eight-bit port
package epa_pkg;
	typedef logic [7:0] epa_byte_t;
	typedef logic [2:0] epa_mode_t;
endpackage : epa_pkg

/* epa_port.sv */
// Eight-bit general purpose port with direction and data registers
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "epa_consts.svh"
module epa_port
	import epa_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   reset_n_i,
	input  wire logic                   hw_standby_i,
	input  wire logic                   sw_standby_i,
	input  wire epa_mode_t              op_mode_i,
	input  wire logic [`EPA_ADDR_W-1:0] addr_i,
	input  wire epa_byte_t              wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output var  epa_byte_t              rdata_o,
	input  wire epa_byte_t              alt_en_i,
	input  wire epa_byte_t              alt_out_i,
	input  wire epa_byte_t              alt_oe_i,
	input  wire epa_byte_t              pin_i,
	output var  epa_byte_t              pin_o,
	output var  epa_byte_t              pin_oe_o
);

	epa_byte_t dir_reg;
	epa_byte_t data_reg;
	epa_byte_t sync1_reg;
	epa_byte_t sync2_reg;
	epa_byte_t rdata_next;
	epa_byte_t pin_next;
	epa_byte_t oe_next;
	epa_byte_t sel_en;
	epa_byte_t sel_out;
	epa_byte_t sel_oe;
	epa_byte_t data_view;
	wire logic hit_dir;
	wire logic hit_data;
	wire logic addr_mode;

	// Only the low sixteen address bits take part in decoding
	assign hit_dir   = (addr_i == `EPA_DIR_OFFSET);
	assign hit_data  = (addr_i == `EPA_DATA_OFFSET);
	assign addr_mode = (op_mode_i == `EPA_MODE_ADDR_A) || (op_mode_i == `EPA_MODE_ADDR_B);

	// Address mode forces pin 7 to the alternate path with its enable on
	always_comb begin
		sel_en  = alt_en_i;
		sel_oe  = alt_oe_i;
		sel_en[`EPA_ADDR_PIN] = alt_en_i[`EPA_ADDR_PIN] | addr_mode;
		sel_oe[`EPA_ADDR_PIN] = alt_oe_i[`EPA_ADDR_PIN] | addr_mode;
		sel_out = alt_out_i;
	end

	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_bit
			// Output pins read back latch, input pins read back the synced level
			assign data_view[b] = dir_reg[b] ? data_reg[b] : sync2_reg[b];
			assign pin_next[b]  = sel_en[b] ? sel_out[b] : data_reg[b];
			assign oe_next[b]   = sel_en[b] ? sel_oe[b] : dir_reg[b];
		end
	endgenerate

	always_comb begin
		if (hit_dir) begin
			rdata_next = `EPA_DIR_READBACK;
		end else if (hit_data) begin
			rdata_next = data_view;
		end else begin
			rdata_next = `EPA_UNMAPPED_READ;
		end
	end

	// Software standby only blocks writes here: registers simply hold
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || hw_standby_i) begin
			dir_reg  <= `EPA_DIR_RESET;
			data_reg <= `EPA_DATA_RESET;
		end else if (wr_i && !sw_standby_i) begin
			if (hit_dir) begin
				dir_reg <= wdata_i;
			end
			if (hit_data) begin
				data_reg <= wdata_i;
			end
		end
	end

	// Pin levels are asynchronous to clk_i, so two stages before use
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdata_o  <= 8'h00;
			pin_o    <= 8'h00;
			pin_oe_o <= 8'h00;
		end else begin
			rdata_o  <= rd_i ? rdata_next : 8'h00;
			pin_o    <= pin_next;
			// Drivers stay on in software standby so outputs hold their level
			pin_oe_o <= hw_standby_i ? 8'h00 : oe_next;
		end
	end

endmodule : epa_port
`default_nettype wire

/* epa_board.sv */
// Board-side model that resolves each port pin
`timescale 1ns/1ps
`default_nettype none
module epa_board import epa_pkg::*; (
	input  wire epa_byte_t pin_o, pin_oe_o, ext_i,
	output wire epa_byte_t lvl_o);
	// Undriven pins settle to the fixed outside pattern, never to a stale value
	assign lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule : epa_board
`default_nettype wire

/* epa_port_monitor.sv */
// Checker for the eight-bit port
`timescale 1ns/1ps
`default_nettype none
module epa_port_monitor import epa_pkg::*; (
	input wire logic clk_i, reset_n_i, hw_standby_i, sw_standby_i, wr_i, rd_i,
	input wire epa_mode_t op_mode_i,
	input wire logic [15:0] addr_i,
	input wire epa_byte_t wdata_i, rdata_o, alt_en_i, alt_out_i, alt_oe_i, pin_o, pin_oe_o);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire pl = !hw_standby_i && alt_en_i == 8'h00 && op_mode_i < 3'h3;
	sequence dw; wr_i && addr_i == 16'hffd1 && !sw_standby_i && pl; endsequence
	sequence sh; (sw_standby_i && pl)[*2]; endsequence
	AST_DRD:assert property(rd_i&&addr_i==16'hffd1|=>rdata_o==8'hff)else $error("dir");
	AST_UNM:assert property(rd_i&&addr_i[15:8]!=8'hff|=>rdata_o==8'h00)else $error("unm");
	AST_IDL:assert property(!rd_i|=>rdata_o==8'h00)else $error("idle");
	AST_HWS:assert property(hw_standby_i|=>pin_oe_o==8'h00)else $error("hw");
	AST_MOD:assert property(!hw_standby_i&&op_mode_i inside {3'h3,3'h4}|=>pin_oe_o[7]
		&&pin_o[7]==$past(alt_out_i[7]))else $error("mode");
	AST_DIR:assert property(dw ##1 pl|=>pin_oe_o==$past(wdata_i,2))else $error("oe");
	AST_SWS:assert property(sh|=>$stable(pin_oe_o))else $error("sw");
	AST_ALT:assert property(!hw_standby_i&&alt_en_i[0]|=>pin_oe_o[0]==$past(alt_oe_i[0])
		&&pin_o[0]==$past(alt_out_i[0]))else $error("alt");
endmodule : epa_port_monitor
bind epa_port epa_port_monitor u_mon(.*);
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the eight-bit port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin checked++;if((a)!==(e))begin err_total++;$display("[ERR] %0t bad %h",$time,a);end end
module testbench;
	logic clk_i=0,reset_n_i=0,hw_standby_i=0,sw_standby_i=0,wr_i=0,rd_i=0;
	logic [2:0] op_mode_i=3'h0;
	logic [15:0] addr_i=16'h0000;
	logic [7:0] wdata_i=8'h00,alt_en_i=8'h00,alt_out_i=8'h80,alt_oe_i=8'h00,rdata_o,pin_i,pin_o,pin_oe_o;
	int err_total=0,checked=0;
	// Row: address, write value, expected read
	logic [31:0] rows[3]='{32'hffd10fff,32'hffd3a535,32'h0fd31100};
	always #20 clk_i=~clk_i;
	epa_port u_epa_port(.*);
	epa_board u_epa_board(.pin_o,.pin_oe_o,.ext_i(8'h3c),.lvl_o(pin_i));
	task automatic acc(input logic w,input logic [15:0] a,input logic [7:0] d);
		@(posedge clk_i) begin wr_i<=w;rd_i<=!w;addr_i<=a;wdata_i<=d;end
		@(posedge clk_i) begin wr_i<=0;rd_i<=0;end
		#1 if(!w) `CHK(rdata_o,d)
	endtask : acc
	task automatic finish_test;
		$display("errors %0d of %0d",err_total,checked);
		if(err_total==0&&checked>0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat(20) @(posedge clk_i);
		reset_n_i<=1;
		foreach(rows[i]) begin
			acc(1,rows[i][31:16],rows[i][15:8]);
			acc(0,rows[i][31:16],rows[i][7:0]);
		end
		acc(0,16'hffd3,8'h35);
		`CHK(pin_oe_o,8'h0f)
		`CHK(pin_o,8'ha5)
		sw_standby_i<=1;
		acc(1,16'hffd1,8'h00);
		acc(0,16'hffd1,8'hff);
		`CHK(pin_oe_o,8'h0f)
		sw_standby_i<=0;op_mode_i<=3'h3;alt_en_i<=8'h01;
		repeat(2) @(posedge clk_i);
		#1 `CHK(pin_oe_o,8'h8e)
		`CHK(pin_o,8'ha4)
		hw_standby_i<=1;
		repeat(2) @(posedge clk_i);
		#1 `CHK(pin_oe_o,8'h00)
		hw_standby_i<=0;op_mode_i<=3'h0;alt_en_i<=8'h00;
		acc(1,16'hffd1,8'hff);
		acc(0,16'hffd3,8'h00);
		finish_test;
	end
	// Run needs under fifty cycles, so this limit only trips on a hang
	initial begin #100000;err_total++;finish_test;end
endmodule : testbench
`default_nettype wire
